// File: pkg/iosa_fld_if.sv
// bit-field request and answer between the executor and the field unit
`timescale 1ns/1ns
interface iosa_fld_if;
   iosa_pkg::iosa_op_t op;   // field operation
   logic [31:0] opd;         // operand holding the field
   logic [31:0] ins;         // data register for insertion
   logic [31:0] off;         // signed field offset, from the msb
   logic [5:0] wid;          // field width, 1 to 32
   logic [31:0] res;         // result value
   logic n;                  // field sign
   logic z;                  // field is all zero
   modport exec (output op, opd, ins, off, wid, input res, n, z);
   modport unit (input op, opd, ins, off, wid, output res, n, z);
endinterface

// File: pkg/iosa_pkg.sv
// shared types, constants and helpers for the integer operation unit
package iosa_pkg;
   // --------------------
   // operation, size and count-source encodings
   // --------------------
   typedef enum logic [4:0] {
      OP_DEC_SUMX, OP_SUM, OP_SUM_PTR, OP_SUM_IMM, OP_SUM_QUICK, OP_SUMX,
      OP_SW_AND, OP_SHL, OP_SHR, OP_BIT_TGL, OP_BIT_CLR, OP_BIT_SET,
      OP_FLD_TGL, OP_FLD_ZERO, OP_FLD_ONES, OP_FLD_INS, OP_FLD_EXTS,
      OP_FLD_FFO, OP_BRK, OP_SUB_BRANCH, OP_BLK16
   } iosa_op_t;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} iosa_size_t;
   typedef enum logic [1:0] {CNT_REG, CNT_IMM, CNT_ONE} iosa_cnt_t;

   // --------------------
   // status word layout and reset value
   // --------------------
   localparam logic [15:0] SW_RESET = 16'h2700;
   localparam int SW_S_POS = 13;
   localparam int FLG_X = 4;
   localparam int FLG_N = 3;
   localparam int FLG_Z = 2;
   localparam int FLG_V = 1;
   localparam int FLG_C = 0;

   // --------------------
   // counts and steps
   // --------------------
   localparam logic [5:0] IMM_ZERO_CNT = 6'h08;    // immediate count 0 means 8
   localparam logic [31:0] QUICK_ZERO = 32'h8;     // quick immediate 0 means 8
   localparam logic [31:0] STACK_STEP = 32'h4;     // bytes per pushed long word
   localparam int BLK_BEATS = 4;                   // long words in one block
   localparam int BLK_ADDR_LSB = 4;                // 16-byte alignment

   // mask of the bits an operand size covers
   function automatic logic [31:0] sz_mask(input iosa_size_t sz);
      case (sz)
         SZ_BYTE: sz_mask = 32'h0000_00FF;
         SZ_WORD: sz_mask = 32'h0000_FFFF;
         default: sz_mask = 32'hFFFF_FFFF;
      endcase
   endfunction

   // sign bit of a value at the given size
   function automatic logic sz_msb(input logic [31:0] v, input iosa_size_t sz);
      case (sz)
         SZ_BYTE: sz_msb = v[7];
         SZ_WORD: sz_msb = v[15];
         default: sz_msb = v[31];
      endcase
   endfunction
endpackage

// File: src/iosa_burst_buf.sv
// small word store for the block transfer, registered read data
`timescale 1ns/1ns
module iosa_burst_buf #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   // clock
   input wire logic i_mclk,
   // write port
   input wire logic i_wr_en,
   input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
   input wire logic [WIDTH-1:0] i_wr_data,
   // read port
   input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
   output logic [WIDTH-1:0] o_rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];   // storage, no reset needed

   // --------------------
   // write and registered read
   // --------------------
   always_ff @(posedge i_mclk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
   end
endmodule

// File: src/iosa_exec.sv
// integer execution unit: sums, shifts, bit and field ops, branches, block move
`timescale 1ns/1ns
// Function
// - left operand is source, right destination
// - decimal add source, destination and extend
// - binary and pointer sums into destination
// - immediate and quick immediate sums
// - add with extend into destination
// - status word conjunction only when supervisor
// - arithmetic shifts by register, immediate, one
// - zero flag gets inverted selected bit first
// - toggle writes inverted selected bit
// - set forces one, clear forces zero
// - field toggle inverts field bits
// - field zero clears field only
// - field ones sets field bits
// - field insert copies register low bits
// - signed extract sign-extends field to register
// - first-one scan returns bit offset
// - breakpoint ack cycle then illegal trap
// - sixteen-byte aligned burst block transfer
module iosa_exec (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // issue from the decoder
   input wire logic i_issue_valid,
   output logic o_issue_ready,
   input wire iosa_pkg::iosa_op_t i_op,
   input wire iosa_pkg::iosa_size_t i_size,
   input wire iosa_pkg::iosa_cnt_t i_cnt_sel,
   input wire logic [31:0] i_src,
   input wire logic [31:0] i_dst,
   input wire logic i_dst_mem,
   input wire logic [31:0] i_fld_off,
   input wire logic [5:0] i_fld_wid,
   input wire logic [31:0] i_pc,
   input wire logic [31:0] i_sp,
   input wire logic [31:0] i_disp,
   // status word load from the core
   input wire logic i_sw_wr,
   input wire logic [15:0] i_sw_wdata,
   // memory cycles
   output logic o_mem_req,
   output logic o_mem_we,
   output logic o_mem_brk_ack,
   output logic [31:0] o_mem_addr,
   output logic [31:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   // results
   output logic o_done,
   output logic [31:0] o_result,
   output logic o_flow_wr,
   output logic [31:0] o_pc,
   output logic [31:0] o_sp,
   output logic [15:0] o_status_word,
   output logic o_trap_priv,
   output logic o_trap_illegal
);
   import iosa_pkg::*;

   // --------------------
   // state and registers
   // --------------------
   typedef enum {ST_IDLE, ST_PUSH, ST_BRK, ST_BLK_RD, ST_BLK_WR} iosa_state_t;
   iosa_state_t state_reg, state_next;
   logic [1:0] beat_reg, beat_next;       // long word within a block
   logic [15:0] sw_reg, sw_next;          // status word
   logic [31:0] result_reg, result_next;  // destination value
   logic [31:0] addr_reg, addr_next;      // push or source block address
   logic [31:0] dst_addr_reg, dst_addr_next;
   logic [31:0] wdata_reg, wdata_next;    // word to push
   logic [31:0] pc_reg, pc_next;
   logic [31:0] sp_reg, sp_next;
   logic done_reg, done_next;
   logic flow_reg, flow_next;
   logic tpriv_reg, tpriv_next;
   logic till_reg, till_next;

   wire logic [31:0] buf_rd;                          // buffered block word
   wire logic take = i_issue_valid && (state_reg == ST_IDLE);
   wire logic [31:0] m = sz_mask(i_size);             // size mask
   wire logic supv = sw_reg[SW_S_POS];                // supervisor state

   // --------------------
   // field unit hookup
   // --------------------
   iosa_fld_if fld ();
   assign fld.op = i_op;
   assign fld.opd = (i_op == OP_FLD_EXTS || i_op == OP_FLD_FFO) ? i_src : i_dst;
   assign fld.ins = i_src;
   assign fld.off = i_fld_off;
   assign fld.wid = i_fld_wid;
   iosa_field_unit u_fld (.fld(fld.unit));

   // --------------------
   // binary sums: source is i_src, destination i_dst
   // --------------------
   wire logic use_x = (i_op == OP_SUMX);
   wire logic [31:0] quick = (i_src[2:0] == 3'h0) ? QUICK_ZERO : {29'h0, i_src[2:0]};
   wire logic [31:0] add_a = ((i_op == OP_SUM_QUICK) ? quick : i_src) & m;
   wire logic [32:0] add_s = {1'b0, add_a} + {1'b0, i_dst & m} + {32'h0, use_x && sw_reg[FLG_X]};
   wire logic add_c = (i_size == SZ_BYTE) ? add_s[8] : (i_size == SZ_WORD) ? add_s[16] : add_s[32];
   wire logic add_n = sz_msb(add_s[31:0], i_size);
   wire logic add_v = (sz_msb(add_a, i_size) == sz_msb(i_dst, i_size)) && (add_n != sz_msb(add_a, i_size));
   wire logic add_z = ((add_s[31:0] & m) == 32'h0);
   wire logic [31:0] ptr_sum = ((i_size == SZ_WORD) ? {{16{i_src[15]}}, i_src[15:0]} : i_src) + i_dst;

   // --------------------
   // packed-decimal sum, one byte
   // --------------------
   logic [4:0] bcd_lo, bcd_hi;
   logic bcd_c;
   always_comb begin
      bcd_lo = {1'b0, i_src[3:0]} + {1'b0, i_dst[3:0]} + {4'h0, sw_reg[FLG_X]};
      if (bcd_lo > 5'h09) begin
         bcd_lo = bcd_lo + 5'h06;
      end
      bcd_hi = {1'b0, i_src[7:4]} + {1'b0, i_dst[7:4]} + {4'h0, bcd_lo[4]};
      bcd_c = (bcd_hi > 5'h09);
      if (bcd_c) begin
         bcd_hi = bcd_hi + 5'h06;
      end
   end
   wire logic [7:0] bcd_r = {bcd_hi[3:0], bcd_lo[3:0]};

   // --------------------
   // arithmetic shifts; the loop unrolls to a barrel of 63 stages
   // --------------------
   wire logic [5:0] cnt = (i_cnt_sel == CNT_ONE) ? 6'h01 :
                          (i_cnt_sel == CNT_REG) ? i_src[5:0] :
                          (i_src[2:0] == 3'h0) ? IMM_ZERO_CNT : {3'h0, i_src[2:0]};
   logic [31:0] sh_v;
   logic sh_c, sh_ov, sh_s;
   always_comb begin
      sh_v = i_dst & m;
      sh_c = 1'b0;
      sh_ov = 1'b0;
      sh_s = 1'b0;
      for (int k = 0; k < 63; k++) begin
         if (6'(k) < cnt) begin
            sh_s = sz_msb(sh_v, i_size);
            if (i_op == OP_SHL) begin
               sh_c = sh_s;
               sh_v = (sh_v << 1) & m;
               // overflow if the sign ever flips during the shift
               sh_ov = sh_ov | (sz_msb(sh_v, i_size) != sh_s);
            end else begin
               sh_c = sh_v[0];
               sh_v = (sh_v >> 1) | (sh_s ? (m ^ (m >> 1)) : 32'h0);
            end
         end
      end
   end

   // --------------------
   // single bit: register bits modulo 32, memory bits modulo 8
   // --------------------
   wire logic [4:0] bnum = i_dst_mem ? {2'h0, i_src[2:0]} : i_src[4:0];
   wire logic [31:0] bsel = 32'h1 << bnum;
   wire logic bold = |(i_dst & bsel);

   // --------------------
   // per-operation results and flags in the idle cycle
   // --------------------
   logic [31:0] op_res;
   logic [15:0] op_sw;
   logic op_trap;
   always_comb begin
      op_res = i_dst;
      op_sw = sw_reg;
      op_trap = 1'b0;
      case (i_op)
         OP_DEC_SUMX: begin
            op_res = {i_dst[31:8], bcd_r};
            op_sw[FLG_X] = bcd_c;
            op_sw[FLG_C] = bcd_c;
            op_sw[FLG_Z] = sw_reg[FLG_Z] && (bcd_r == 8'h00);   // zero only sticks
         end
         OP_SUM, OP_SUM_IMM, OP_SUM_QUICK, OP_SUMX: begin
            op_res = (i_dst & ~m) | (add_s[31:0] & m);
            op_sw[FLG_X] = add_c;
            op_sw[FLG_N] = add_n;
            op_sw[FLG_Z] = use_x ? (sw_reg[FLG_Z] && add_z) : add_z;
            op_sw[FLG_V] = add_v;
            op_sw[FLG_C] = add_c;
         end
         OP_SUM_PTR: op_res = ptr_sum;   // flags untouched
         OP_SW_AND: begin
            if (supv) begin
               op_sw = sw_reg & i_src[15:0];
            end else begin
               op_trap = 1'b1;
               op_sw = sw_reg;
            end
         end
         OP_SHL, OP_SHR: begin
            op_res = (i_dst & ~m) | sh_v;
            op_sw[FLG_N] = sz_msb(sh_v, i_size);
            op_sw[FLG_Z] = (sh_v == 32'h0);
            op_sw[FLG_V] = sh_ov;
            op_sw[FLG_C] = sh_c;
            if (cnt != 6'h00) begin
               op_sw[FLG_X] = sh_c;   // zero count leaves extend alone
            end
         end
         OP_BIT_TGL, OP_BIT_CLR, OP_BIT_SET: begin
            op_sw[FLG_Z] = ~bold;
            case (i_op)
               OP_BIT_TGL: op_res = i_dst ^ bsel;
               OP_BIT_CLR: op_res = i_dst & ~bsel;
               default: op_res = i_dst | bsel;
            endcase
         end
         OP_FLD_TGL, OP_FLD_ZERO, OP_FLD_ONES, OP_FLD_INS, OP_FLD_EXTS, OP_FLD_FFO: begin
            op_res = fld.res;
            op_sw[FLG_N] = fld.n;
            op_sw[FLG_Z] = fld.z;
            op_sw[FLG_V] = 1'b0;
            op_sw[FLG_C] = 1'b0;
         end
         default: op_res = i_dst;
      endcase
   end

   // --------------------
   // sequencer: next values
   // --------------------
   always_comb begin
      state_next = state_reg;
      beat_next = beat_reg;
      sw_next = sw_reg;
      result_next = result_reg;
      addr_next = addr_reg;
      dst_addr_next = dst_addr_reg;
      wdata_next = wdata_reg;
      pc_next = pc_reg;
      sp_next = sp_reg;
      done_next = 1'b0;
      flow_next = 1'b0;
      tpriv_next = 1'b0;
      till_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (take) begin
               case (i_op)
                  OP_SUB_BRANCH: begin
                     addr_next = i_sp - STACK_STEP;
                     wdata_next = i_pc;
                     state_next = ST_PUSH;
                  end
                  OP_BRK: state_next = ST_BRK;
                  OP_BLK16: begin
                     addr_next = {i_src[31:BLK_ADDR_LSB], 4'h0};
                     dst_addr_next = {i_dst[31:BLK_ADDR_LSB], 4'h0};
                     beat_next = 2'h0;
                     state_next = ST_BLK_RD;
                  end
                  default: begin
                     // a trap leaves result and status word as they were
                     tpriv_next = op_trap;
                     done_next = ~op_trap;
                     sw_next = op_sw;
                     result_next = op_trap ? result_reg : op_res;
                  end
               endcase
            end
         end
         ST_PUSH: begin
            if (i_mem_ack) begin
               sp_next = addr_reg;
               pc_next = wdata_reg + i_disp;
               flow_next = 1'b1;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_BRK: begin
            if (i_mem_ack) begin
               till_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_BLK_RD: begin
            if (i_mem_ack) begin
               beat_next = beat_reg + 2'h1;
               if (beat_reg == 2'(BLK_BEATS - 1)) begin
                  state_next = ST_BLK_WR;
               end
            end
         end
         ST_BLK_WR: begin
            if (i_mem_ack) begin
               beat_next = beat_reg + 2'h1;
               if (beat_reg == 2'(BLK_BEATS - 1)) begin
                  done_next = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase
      if (i_sw_wr) begin
         sw_next = i_sw_wdata;   // core load takes precedence
      end
   end

   // --------------------
   // registers
   // --------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state_reg <= ST_IDLE;
         beat_reg <= 2'h0;
         sw_reg <= SW_RESET;
         result_reg <= 32'h0;
         addr_reg <= 32'h0;
         dst_addr_reg <= 32'h0;
         wdata_reg <= 32'h0;
         pc_reg <= 32'h0;
         sp_reg <= 32'h0;
         {done_reg, flow_reg, tpriv_reg, till_reg} <= 4'h0;
      end else begin
         state_reg <= state_next;
         beat_reg <= beat_next;
         sw_reg <= sw_next;
         result_reg <= result_next;
         addr_reg <= addr_next;
         dst_addr_reg <= dst_addr_next;
         wdata_reg <= wdata_next;
         pc_reg <= pc_next;
         sp_reg <= sp_next;
         {done_reg, flow_reg, tpriv_reg, till_reg} <= {done_next, flow_next, tpriv_next, till_next};
      end
   end

   // --------------------
   // block store: read ahead with beat_next so data is ready on time
   // --------------------
   iosa_burst_buf #(.WIDTH(32), .DEPTH(BLK_BEATS)) u_buf (
      .i_mclk(i_mclk),
      .i_wr_en((state_reg == ST_BLK_RD) && i_mem_ack),
      .i_wr_addr(beat_reg),
      .i_wr_data(i_mem_rdata),
      .i_rd_addr(beat_next),
      .o_rd_data(buf_rd)
   );

   // --------------------
   // outputs
   // --------------------
   wire logic blk = (state_reg == ST_BLK_RD) || (state_reg == ST_BLK_WR);
   assign o_issue_ready = (state_reg == ST_IDLE);
   assign o_mem_req = (state_reg != ST_IDLE);
   assign o_mem_we = (state_reg == ST_PUSH) || (state_reg == ST_BLK_WR);
   assign o_mem_brk_ack = (state_reg == ST_BRK);
   assign o_mem_addr = !blk ? addr_reg :
                       {(state_reg == ST_BLK_WR) ? dst_addr_reg[31:4] : addr_reg[31:4], beat_reg, 2'h0};
   assign o_mem_wdata = (state_reg == ST_BLK_WR) ? buf_rd : wdata_reg;
   assign o_done = done_reg;
   assign o_result = result_reg;
   assign o_flow_wr = flow_reg;
   assign o_pc = pc_reg;
   assign o_sp = sp_reg;
   assign o_status_word = sw_reg;
   assign o_trap_priv = tpriv_reg;
   assign o_trap_illegal = till_reg;
endmodule

// File: src/iosa_field_unit.sv
// combinational bit-field engine, fields counted from the msb
`timescale 1ns/1ns
module iosa_field_unit (
   // request and answer
   iosa_fld_if.unit fld
);
   import iosa_pkg::*;

   logic [31:0] fmask;   // field bits in the operand
   logic [31:0] fval;    // field right-justified
   logic [31:0] ipos;    // insert data placed at field bits
   logic [31:0] first;   // offset of the first set bit
   logic found;          // a set bit was seen
   logic [4:0] p;        // msb-relative position
   logic [5:0] k6;       // loop index at width of wid

   // --------------------
   // mask, extraction and placement
   // --------------------
   always_comb begin
      fmask = '0;
      fval = '0;
      ipos = '0;
      found = 1'b0;
      p = '0;
      k6 = '0;
      first = fld.off + {26'h0, fld.wid};   // none set: offset plus width
      for (int j = 0; j < 32; j++) begin
         k6 = 6'(j);
         if (k6 < fld.wid) begin
            // field bit j counts up from the field's lsb
            p = 5'(fld.off + 32'(fld.wid) - 32'h1 - 32'(j));
            fmask[31 - p] = 1'b1;
            fval[j] = fld.opd[31 - p];
            ipos[31 - p] = fld.ins[j];
            // scan from the field's msb for the first one
            p = 5'(fld.off + 32'(j));
            if (!found && fld.opd[31 - p]) begin
               found = 1'b1;
               first = fld.off + 32'(j);
            end
         end
      end
   end

   wire logic fsign = fval[5'(fld.wid - 6'h1)];   // field msb

   // --------------------
   // result select and flags
   // --------------------
   always_comb begin
      fld.n = fsign;
      fld.z = (fval == 32'h0);
      case (fld.op)
         OP_FLD_TGL: fld.res = fld.opd ^ fmask;
         OP_FLD_ZERO: fld.res = fld.opd & ~fmask;
         OP_FLD_ONES: fld.res = fld.opd | fmask;
         OP_FLD_INS: begin
            fld.res = (fld.opd & ~fmask) | ipos;
            fld.n = fld.ins[5'(fld.wid - 6'h1)];
            fld.z = ((ipos & fmask) == 32'h0);
         end
         OP_FLD_EXTS: fld.res = fval | (fsign ? ~((32'h1 << fld.wid) - 32'h1) : 32'h0);
         OP_FLD_FFO: fld.res = first;
         default: fld.res = fld.opd;
      endcase
   end
endmodule

// File: tb/iosa_exec_bench.sv
// self-checking bench for the integer execution unit
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin num_checks++; if ((ex) !== (gt)) begin error_cnt++; \
   $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module iosa_exec_bench;
   import iosa_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_issue_valid = 1'b0, i_sw_wr = 1'b0, i_mem_ack = 1'b0, i_dst_mem = 1'b0;
   iosa_op_t i_op = OP_SUM;
   iosa_size_t i_size = SZ_LONG;
   iosa_cnt_t i_cnt_sel = CNT_IMM;
   logic [31:0] i_src = 32'h0, i_dst = 32'h0, i_fld_off = 32'h0, i_pc = 32'h0, i_sp = 32'h0;
   logic [31:0] i_disp = 32'h0, i_mem_rdata = 32'h0, e_pc, e_sp, sb, db;
   logic [5:0] i_fld_wid = 6'h01;
   logic [15:0] i_sw_wdata = 16'h271F;
   wire logic o_issue_ready, o_mem_req, o_mem_we, o_mem_brk_ack, o_done, o_flow_wr, o_trap_priv, o_trap_illegal;
   wire logic [31:0] o_mem_addr, o_mem_wdata, o_result, o_pc, o_sp;
   wire logic [15:0] o_status_word;
   int error_cnt = 0, num_checks = 0, cycles = 0, n_ill = 0, n_priv = 0;
   logic [34:0] exp_q[$]; // check result, check zero flag, zero flag, result
   logic blk = 1'b0;
   iosa_exec i_dut (.*);
   always #5 i_mclk = ~i_mclk;
   task automatic close_out;
      if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, far above the roughly 1300 cycles the run needs
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   // offer one operation, hold it until an edge where the unit is ready and takes it, note its expected answer
   task automatic issue(input iosa_op_t op, input logic [31:0] s, d, input logic pd, input logic [34:0] e);
      @(posedge i_mclk);
      i_issue_valid <= 1'b1;
      i_op <= op;
      i_src <= s;
      i_dst <= d;
      do @(posedge i_mclk); while (o_issue_ready !== 1'b1);
      i_issue_valid <= 1'b0;
      if (pd) exp_q.push_back(e);
   endtask
   // ---------------------------------------------------------------
   // memory responder: ack one cycle after request, data is ~address
   // ---------------------------------------------------------------
   always @(posedge i_mclk) begin
      i_mem_ack <= o_mem_req === 1'b1 && !i_mem_ack;
      i_mem_rdata <= ~o_mem_addr;
      if (o_mem_req === 1'b1 && i_mem_ack && o_mem_we === 1'b1) begin
         if (blk) `CHK("blk data", ~(sb + o_mem_addr - db), o_mem_wdata)
         else begin
            `CHK("push addr", e_sp, o_mem_addr)
            `CHK("push data", i_pc, o_mem_wdata)
         end
      end
   end
   // result watcher: every done pulse takes the oldest note
   always @(posedge i_mclk) begin
      logic [34:0] e;
      n_ill += (o_trap_illegal === 1'b1);
      n_priv += (o_trap_priv === 1'b1);
      if (o_flow_wr === 1'b1) begin
         `CHK("pc", e_pc, o_pc)
         `CHK("sp", e_sp, o_sp)
      end
      if (o_done === 1'b1 && exp_q.size() == 0) `CHK("done", 1'b0, 1'b1)
      else if (o_done === 1'b1) begin
         e = exp_q.pop_front();
         if (e[34]) `CHK("result", e[31:0], o_result)
         if (e[33]) `CHK("zero flag", e[32], o_status_word[FLG_Z])
      end
   end
   initial begin
      logic [31:0] a, b, m, r;
      logic [5:0] w, o;
      logic x;
      int n;
      void'($urandom(29));
      repeat (16) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      for (int k = 0; k < 40; k++) begin
         a = $urandom;
         b = $urandom;
         {x, r} = {1'b0, a} + b;
         issue(OP_SUM, a, b, 1'b1, {3'b100, r});
         b = $urandom;
         {x, r} = {1'b0, a} + b + x;
         issue(OP_SUMX, a, b, 1'b1, {3'b100, r});
         issue(OP_SUM_PTR, a, b, 1'b1, {3'b100, a + b});
         issue(OP_SUM_IMM, a, r, 1'b1, {3'b100, a + r});
         n = k % 8;
         issue(OP_SUM_QUICK, n, b, 1'b1, {3'b100, b + (n == 0 ? 32'h8 : n)});
         n = $urandom_range(31, 0);
         i_dst_mem <= k[0];
         o = k[0] ? n % 8 : n;
         m = 32'h1 << o;
         issue(OP_BIT_TGL, n, b, 1'b1, {2'b11, ~b[o], b ^ m});
         issue(OP_BIT_SET, n, b, 1'b1, {2'b11, ~b[o], b | m});
         issue(OP_BIT_CLR, n, b, 1'b1, {2'b11, ~b[o], b & ~m});
         n = (k % 3 == 2) ? 1 : $urandom_range(8, 1);
         i_cnt_sel <= iosa_cnt_t'(k % 3);
         issue(OP_SHL, n, b, 1'b1, {3'b100, b << n});
         issue(OP_SHR, n, b, 1'b1, {3'b100, $unsigned($signed(b) >>> n)});
         w = $urandom_range(32, 1);
         o = $urandom_range(32 - w, 0);
         m = 32'(((64'h1 << w) - 1) << (32 - o - w));
         r = (b & m) >> (32 - o - w);
         r = (r ^ (32'h1 << (w - 1))) - (32'h1 << (w - 1));
         i_fld_off <= 32'(o);
         i_fld_wid <= w;
         issue(OP_FLD_TGL, a, b, 1'b1, {3'b100, b ^ m});
         issue(OP_FLD_ZERO, a, b, 1'b1, {3'b100, b & ~m});
         issue(OP_FLD_ONES, a, b, 1'b1, {3'b100, b | m});
         issue(OP_FLD_INS, a, b, 1'b1, {3'b100, (b & ~m) | ((a << (32 - o - w)) & m)});
         issue(OP_FLD_EXTS, b, b, 1'b1, {3'b100, r});
      end
      a = $urandom & 32'hFFFF_FFFC;
      b = $urandom;
      r = $urandom;
      e_sp = a - 32'h4;
      e_pc = b + r;
      i_sp <= a;
      i_pc <= b;
      i_disp <= r;
      issue(OP_SUB_BRANCH, 32'h0, 32'h0, 1'b1, 35'h0);
      issue(OP_BRK, 32'h0, 32'h0, 1'b0, 35'h0);
      sb = $urandom & 32'hFFFF_FFF0;
      db = $urandom & 32'hFFFF_FFF0;
      blk = 1'b1;
      issue(OP_BLK16, sb | 32'h7, db | 32'h9, 1'b1, 35'h0);
      i_sw_wr <= 1'b1;
      @(posedge i_mclk);
      i_sw_wr <= 1'b0;
      @(posedge i_mclk);
      `CHK("sw load", 16'h271F, o_status_word)
      issue(OP_SW_AND, 32'hDFFF, 32'h0, 1'b1, 35'h0);
      repeat (2) @(posedge i_mclk);
      `CHK("sw super", 16'h071F, o_status_word)
      issue(OP_SW_AND, 32'h0, 32'h0, 1'b0, 35'h0);
      repeat (5) @(posedge i_mclk);
      `CHK("sw user", 16'h071F, o_status_word)
      `CHK("priv traps", 1, n_priv)
      `CHK("illegal traps", 1, n_ill)
      `CHK("pending", 0, exp_q.size())
      close_out();
   end
endmodule

// File: tb/iosa_exec_props.sv
// assertion checker for the integer execution unit
`timescale 1ns/1ns
module iosa_exec_props
   import iosa_pkg::*;
(
   // watched ports
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_issue_valid,
   input wire logic o_issue_ready,
   input wire iosa_pkg::iosa_op_t i_op,
   input wire logic [31:0] i_src,
   input wire logic i_dst_mem,
   input wire logic i_sw_wr,
   input wire logic i_mem_ack,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic o_mem_brk_ack,
   input wire logic [31:0] o_mem_addr,
   input wire logic o_done,
   input wire logic [31:0] o_result,
   input wire logic [15:0] o_status_word,
   input wire logic o_trap_priv,
   input wire logic o_trap_illegal
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // a request is taken only while the unit is idle
   wire logic take = i_issue_valid && o_issue_ready;
   // a core load in the same edge would change the status word, so it is left out
   wire logic user_and = take && i_op == OP_SW_AND && !o_status_word[SW_S_POS] && !i_sw_wr;
   property p_priv_trap; user_and |=> o_trap_priv && !o_done; endproperty
   a_priv_trap: assert property (p_priv_trap) else $error("user conjunction did not trap");
   property p_priv_keep; user_and |=> $stable(o_status_word) && $stable(o_result); endproperty
   a_priv_keep: assert property (p_priv_keep) else $error("trapped conjunction changed state");
   property p_super_and; take && i_op == OP_SW_AND && o_status_word[SW_S_POS] |=> o_done && !o_trap_priv; endproperty
   a_super_and: assert property (p_super_and) else $error("supervisor conjunction not done");
   property p_sum_done; take && i_op == OP_SUM |=> o_done; endproperty
   a_sum_done: assert property (p_sum_done) else $error("sum not done next cycle");
   property p_bit_set; take && i_op == OP_BIT_SET && !i_dst_mem |=> o_result[$past(i_src[4:0])]; endproperty
   a_bit_set: assert property (p_bit_set) else $error("selected bit not set");
   property p_bit_clr; take && i_op == OP_BIT_CLR && !i_dst_mem |=> !o_result[$past(i_src[4:0])]; endproperty
   a_bit_clr: assert property (p_bit_clr) else $error("selected bit not cleared");
   property p_brk_cycle; take && i_op == OP_BRK |=> o_mem_req && o_mem_brk_ack && !o_mem_we; endproperty
   a_brk_cycle: assert property (p_brk_cycle) else $error("no breakpoint acknowledge cycle");
   property p_brk_trap; o_mem_req && o_mem_brk_ack && i_mem_ack |=> o_trap_illegal; endproperty
   a_brk_trap: assert property (p_brk_trap) else $error("no illegal trap after acknowledge");
   property p_req_hold; o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr); endproperty
   a_req_hold: assert property (p_req_hold) else $error("memory request dropped or moved");
   property p_rd_align; o_mem_req && !o_mem_we && !o_mem_brk_ack |-> o_mem_addr[1:0] == 2'h0; endproperty
   a_rd_align: assert property (p_rd_align) else $error("block read not word aligned");
   // eight beats need at least eight cycles, so the unit stays busy that long
   property p_blk_busy; take && i_op == OP_BLK16 |=> !o_issue_ready [*8]; endproperty
   a_blk_busy: assert property (p_blk_busy) else $error("block transfer ended too soon");
   c_blk: cover property (take && i_op == OP_BLK16);
   c_user: cover property (user_and);
   c_ill: cover property (o_trap_illegal);
endmodule
bind iosa_exec iosa_exec_props i_props (.*);
